/* rtl/sab_sequencer.sv */
// Converter sequencer: subsystem clock selection, tracking and conversion timing,
// burst series with accumulation, result formatting and end-of-conversion flag.
// Assumes the analog core presents a settled 12-bit code on SAR_DATA_IN while finishing.
//
// What this block does
// - Subsystem tick is every system clock, or burst oscillator rising edges in burst mode.
// - Conversion clock is the subsystem clock divided by the divider field plus one.
// - Sequencer is never tracking and converting at the same time.
// - Pre-tracking mode converts right after a normal-mode convert start, with no hardware tracking; burst starts still track.
// - Post and dual tracking track for field plus 2 subsystem cycles, then convert.
// - A conversion lasts 13 conversion clocks plus 2 subsystem cycles.
// - Burst mode takes and sums 1, 4, 8 or 16 samples per start, then returns to idle.
// - In burst mode the enable bit chooses powered down or enabled between bursts.
// - Burst start powers up and waits power-up time if down, else tracks at once.
// - Burst start runs the full repeat count; normal mode needs a start per conversion.
// - End-of-conversion flag and window compare come only after the full repeat count.
// - Repeat count 1 gives a 12-bit unsigned result after every conversion.
// - Justify bit picks right layout 0x0FFF or left layout 0xFFF0; spare bits zero.
// - Repeat above 1 gives the unsigned sum, updated after the series ends.
// - The repeat count field selects the repeat count.
// - Tracking mode codes: pre 10b, post 01b, dual 11b.
// - Busy is high while converting; its fall after the last sample of a series sets the flag and raises the event.
// - Post tracking disconnects the input after conversion; dual tracking tracks again while the converter stays powered.
`timescale 1ns/1ps
`include "sab_defines.svh"

module sab_sequencer (
   input  wire logic                     MCLK_IN,
   input  wire logic                     RST_B_IN,
   input  wire logic                     BURST_OSC_IN,
   input  wire logic                     CONV_START_IN,
   input  wire logic                     BURST_ENABLE_BIT_IN,
   input  wire logic                     CONVERTER_ENABLE_BIT_IN,
   input  wire logic [`SAB_DIV_W-1:0]    SAR_CLK_DIVIDER_IN,
   input  wire logic [`SAB_TRACK_W-1:0]  TRACK_TIME_FIELD_IN,
   input  wire logic [1:0]               TRACK_MODE_FIELD_IN,
   input  wire logic [`SAB_PWRUP_W-1:0]  POWERUP_TIME_FIELD_IN,
   input  wire logic                     JUSTIFY_BIT_IN,
   input  wire logic [1:0]               REPEAT_COUNT_FIELD_IN,
   input  wire logic                     EOC_FLAG_CLR_IN,
   input  wire logic [`SAB_SAMPLE_W-1:0] SAR_DATA_IN,
   output logic                          CONV_BUSY_BIT_OUT,
   output logic                          EOC_FLAG_OUT,
   output logic                          EOC_PULSE_OUT,
   output logic                          WINDOW_COMPARE_OUT,
   output logic [7:0]                    RESULT_HIGH_BYTE_OUT,
   output logic [7:0]                    RESULT_LOW_BYTE_OUT,
   output logic                          TRACKING_OUT,
   output logic                          CONVERTING_OUT,
   output logic                          POWER_ON_OUT,
   output logic                          SAR_CLK_OUT
);

   sab_pkg::sab_seq_type       r;
   sab_pkg::sab_seq_type       next_r;
   logic                       start_evt;
   logic                       osc_rise;
   logic                       subsys_tick;
   logic                       sar_tick;
   logic [`SAB_SAMPLES_W-1:0]  rep_total;
   logic [`SAB_SAMPLES_W-1:0]  samples_done;
   logic [`SAB_RESULT_W-1:0]   sample_ext;
   logic [`SAB_RESULT_W-1:0]   sum;
   logic [`SAB_CNT_W-1:0]      track_load;
   logic [`SAB_CNT_W-1:0]      pwrup_load;
   logic                       pre_mode;
   logic                       last_sample;

   sab_sync_edge u_start_sync (
      .clk_in    (MCLK_IN),
      .rst_b_in  (RST_B_IN),
      .d_in      (CONV_START_IN),
      .level_out (),
      .rise_out  (start_evt)
   );

   sab_sync_edge u_osc_sync (
      .clk_in    (MCLK_IN),
      .rst_b_in  (RST_B_IN),
      .d_in      (BURST_OSC_IN),
      .level_out (),
      .rise_out  (osc_rise)
   );

   // Burst oscillator runs below half the system clock, so its edges are sampled cleanly
   assign subsys_tick = BURST_ENABLE_BIT_IN ? osc_rise : 1'b1;

   sab_tick_divider u_sar_div (
      .clk_in     (MCLK_IN),
      .rst_b_in   (RST_B_IN),
      .restart_in (r.state != sab_pkg::SAB_CONV),
      .tick_in    (subsys_tick),
      .ratio_in   (SAR_CLK_DIVIDER_IN),
      .tick_out   (sar_tick)
   );

   always_comb begin
      case (REPEAT_COUNT_FIELD_IN)
         `SAB_RPT_1:  rep_total = 5'h01;
         `SAB_RPT_4:  rep_total = 5'h04;
         `SAB_RPT_8:  rep_total = 5'h08;
         `SAB_RPT_16: rep_total = 5'h10;
         default:     rep_total = 5'h01;
      endcase
   end

   assign pre_mode     = (TRACK_MODE_FIELD_IN == `SAB_MODE_PRE);
   assign track_load   = `SAB_CNT_W'(TRACK_TIME_FIELD_IN) + `SAB_TRACK_EXTRA - 8'h01;
   assign pwrup_load   = `SAB_CNT_W'((`SAB_CNT_W'(POWERUP_TIME_FIELD_IN) + 8'h01) * `SAB_PWRUP_UNIT - 8'h01);
   assign sample_ext   = {4'h0, SAR_DATA_IN};
   // First sample of a series replaces the running sum
   assign sum          = (r.samples == '0) ? sample_ext : r.acc + sample_ext;
   assign samples_done = r.samples + `SAB_SAMPLES_W'(1);
   assign last_sample  = (samples_done == rep_total);

   always_comb begin
      next_r            = r;
      next_r.eoc_pulse  = 1'b0;
      next_r.win_strobe = 1'b0;
      if (EOC_FLAG_CLR_IN) begin
         next_r.eoc = 1'b0;
      end
      case (r.state)
         sab_pkg::SAB_IDLE: begin
            if (start_evt) begin
               next_r.burst_run = BURST_ENABLE_BIT_IN;
               if (BURST_ENABLE_BIT_IN) begin
                  next_r.busy = 1'b1;
                  // A powered-down converter waits out its power-up time first
                  if (CONVERTER_ENABLE_BIT_IN) begin
                     next_r.state = sab_pkg::SAB_TRACK;
                     next_r.cnt   = track_load;
                  end else begin
                     next_r.state = sab_pkg::SAB_POWERUP;
                     next_r.cnt   = pwrup_load;
                  end
               end else if (CONVERTER_ENABLE_BIT_IN) begin
                  next_r.busy = 1'b1;
                  if (pre_mode) begin
                     next_r.state = sab_pkg::SAB_CONV_START;
                  end else begin
                     next_r.state = sab_pkg::SAB_TRACK;
                     next_r.cnt   = track_load;
                  end
               end
            end
         end
         sab_pkg::SAB_POWERUP: begin
            if (subsys_tick) begin
               if (r.cnt == '0) begin
                  next_r.state = sab_pkg::SAB_TRACK;
                  next_r.cnt   = track_load;
               end else begin
                  next_r.cnt = r.cnt - `SAB_CNT_W'(1);
               end
            end
         end
         sab_pkg::SAB_TRACK: begin
            if (subsys_tick) begin
               if (r.cnt == '0) begin
                  next_r.state = sab_pkg::SAB_CONV_START;
               end else begin
                  next_r.cnt = r.cnt - `SAB_CNT_W'(1);
               end
            end
         end
         sab_pkg::SAB_CONV_START: begin
            if (subsys_tick) begin
               next_r.state   = sab_pkg::SAB_CONV;
               next_r.sar_cnt = '0;
            end
         end
         sab_pkg::SAB_CONV: begin
            if (sar_tick) begin
               if (r.sar_cnt == `SAB_CONV_SAR_CYCLES - 4'h1) begin
                  next_r.state = sab_pkg::SAB_CONV_END;
               end else begin
                  next_r.sar_cnt = r.sar_cnt + `SAB_SAR_CNT_W'(1);
               end
            end
         end
         sab_pkg::SAB_CONV_END: begin
            if (subsys_tick) begin
               next_r.acc = sum;
               if (last_sample) begin
                  next_r.samples    = '0;
                  next_r.state      = sab_pkg::SAB_IDLE;
                  next_r.busy       = 1'b0;
                  // Flag and result move together so a read never sees half an update
                  next_r.eoc        = 1'b1;
                  next_r.eoc_pulse  = 1'b1;
                  next_r.win_strobe = 1'b1;
                  if (rep_total != 5'h01) begin
                     next_r.result = sum;
                  end else if (JUSTIFY_BIT_IN) begin
                     next_r.result = {SAR_DATA_IN, 4'h0};
                  end else begin
                     next_r.result = sample_ext;
                  end
               end else begin
                  next_r.samples = samples_done;
                  if (r.burst_run) begin
                     next_r.state = sab_pkg::SAB_TRACK;
                     next_r.cnt   = track_load;
                  end else begin
                     // Normal mode waits for the next start for each conversion
                     next_r.state = sab_pkg::SAB_IDLE;
                     next_r.busy  = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_r.state = sab_pkg::SAB_IDLE;
         end
      endcase

      next_r.converting = (next_r.state == sab_pkg::SAB_CONV_START) ||
                          (next_r.state == sab_pkg::SAB_CONV) ||
                          (next_r.state == sab_pkg::SAB_CONV_END);
      // Burst idle power follows the enable bit; normal mode is powered by it alone
      next_r.power      = CONVERTER_ENABLE_BIT_IN ||
                          (next_r.state != sab_pkg::SAB_IDLE);
      if (next_r.state == sab_pkg::SAB_TRACK) begin
         next_r.tracking = 1'b1;
      end else if (next_r.converting || !next_r.power) begin
         next_r.tracking = 1'b0;
      end else if (next_r.state == sab_pkg::SAB_POWERUP) begin
         next_r.tracking = (TRACK_MODE_FIELD_IN == `SAB_MODE_DUAL);
      end else begin
         // Post tracking leaves the input disconnected until the next start
         next_r.tracking = (TRACK_MODE_FIELD_IN != `SAB_MODE_POST);
      end
      next_r.sar_clk = sar_tick && (r.state == sab_pkg::SAB_CONV);
   end

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         r        <= '0;
         r.state  <= sab_pkg::SAB_IDLE;
         r.result <= `SAB_RESULT_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign CONV_BUSY_BIT_OUT    = r.busy;
   assign EOC_FLAG_OUT         = r.eoc;
   assign EOC_PULSE_OUT        = r.eoc_pulse;
   assign WINDOW_COMPARE_OUT   = r.win_strobe;
   assign RESULT_HIGH_BYTE_OUT = r.result[15:8];
   assign RESULT_LOW_BYTE_OUT  = r.result[7:0];
   assign TRACKING_OUT         = r.tracking;
   assign CONVERTING_OUT       = r.converting;
   assign POWER_ON_OUT         = r.power;
   assign SAR_CLK_OUT          = r.sar_clk;

endmodule

/* common/sab_defines.svh */
// Constants for the converter sequencer: field widths, encodings, reset values and timing counts.
// Included by bare name; holds definitions only.
`ifndef SAB_DEFINES_SVH
`define SAB_DEFINES_SVH

`define SAB_SAMPLE_W      12
`define SAB_RESULT_W      16
`define SAB_DIV_W         5
`define SAB_TRACK_W       2
`define SAB_PWRUP_W       5
`define SAB_CNT_W         8
`define SAB_SAR_CNT_W     4
`define SAB_SAMPLES_W     5

`define SAB_MODE_PRE      2'h2
`define SAB_MODE_POST     2'h1
`define SAB_MODE_DUAL     2'h3

`define SAB_RPT_1         2'h0
`define SAB_RPT_4         2'h1
`define SAB_RPT_8         2'h2
`define SAB_RPT_16        2'h3

`define SAB_CONV_SAR_CYCLES  4'hd
`define SAB_TRACK_EXTRA      8'h02
`define SAB_PWRUP_UNIT       8'h08
`define SAB_BURST_OSC_MAX_MHZ 25
`define SAB_SYS_CLK_MHZ       100

`define SAB_RESULT_RESET  16'h0000

`endif

/* common/sab_pkg.sv */
// Types shared by the converter sequencer modules.
// Needs sab_defines.svh on the include path.
`include "sab_defines.svh"

package sab_pkg;

   typedef enum logic [2:0] {
      SAB_IDLE,
      SAB_POWERUP,
      SAB_TRACK,
      SAB_CONV_START,
      SAB_CONV,
      SAB_CONV_END
   } sab_state_type;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sab_sync_type;

   typedef struct packed {
      logic [`SAB_DIV_W-1:0] count;
   } sab_div_type;

   typedef struct packed {
      sab_state_type              state;
      logic [`SAB_CNT_W-1:0]      cnt;
      logic [`SAB_SAR_CNT_W-1:0]  sar_cnt;
      logic [`SAB_SAMPLES_W-1:0]  samples;
      logic [`SAB_RESULT_W-1:0]   acc;
      logic [`SAB_RESULT_W-1:0]   result;
      logic                       burst_run;
      logic                       eoc;
      logic                       busy;
      logic                       tracking;
      logic                       converting;
      logic                       power;
      logic                       sar_clk;
      logic                       eoc_pulse;
      logic                       win_strobe;
   } sab_seq_type;

endpackage

/* rtl/sab_sync_edge.sv */
// Two-flop synchroniser for an asynchronous pin with a rising-edge detector behind it.
// Single clock; the edge pulse lasts one clock cycle.
`timescale 1ns/1ps

module sab_sync_edge (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic d_in,
   output logic      level_out,
   output logic      rise_out
);

   sab_pkg::sab_sync_type r;
   sab_pkg::sab_sync_type next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = d_in;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign level_out = r.s2;
   assign rise_out  = r.s2 & ~r.s3;

endmodule

/* rtl/sab_tick_divider.sv */
// Divides a stream of one-cycle ticks by ratio+1 and emits one tick per period.
// restart_in holds the count at zero so the first output comes a full period later.
`timescale 1ns/1ps
`include "sab_defines.svh"

module sab_tick_divider (
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  restart_in,
   input  wire logic                  tick_in,
   input  wire logic [`SAB_DIV_W-1:0] ratio_in,
   output logic                       tick_out
);

   sab_pkg::sab_div_type r;
   sab_pkg::sab_div_type next_r;
   logic                 wrap;

   assign wrap = tick_in && (r.count == ratio_in);

   always_comb begin
      next_r = r;
      if (restart_in) begin
         next_r.count = '0;
      end else if (wrap) begin
         next_r.count = '0;
      end else if (tick_in) begin
         next_r.count = r.count + `SAB_DIV_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick_out = wrap && !restart_in;

endmodule

/* verif/sab_analog_model.sv */
// Behavioural analog core beside the sequencer: burst oscillator and conversion code.
// Assumes the bench holds code_in steady for the whole of each conversion.
`timescale 1ns/1ps

module sab_analog_model (
   input  wire logic        conv_in,
   input  wire logic [11:0] code_in,
   output logic             osc_out,
   output logic [11:0]      data_out
);
   initial begin
      osc_out = 1'b0;
      forever #20 osc_out = ~osc_out; // 25 MHz free-running oscillator
   end
   // Outside a conversion the code is not settled, so show the inverse
   assign data_out = conv_in ? code_in : ~code_in;
endmodule

/* verif/sab_sequencer_monitor.sv */
// Checker bound to the converter sequencer top module.
// Sees only the top module ports; one clock domain.
`timescale 1ns/1ps
`include "sab_defines.svh"

module sab_sequencer_monitor (
   input  wire logic       MCLK_IN,
   input  wire logic       RST_B_IN,
   input  wire logic       BURST_ENABLE_BIT_IN,
   input  wire logic       CONVERTER_ENABLE_BIT_IN,
   input  wire logic [1:0] TRACK_MODE_FIELD_IN,
   input  wire logic [1:0] REPEAT_COUNT_FIELD_IN,
   input  wire logic       CONV_BUSY_BIT_OUT,
   input  wire logic       EOC_FLAG_OUT,
   input  wire logic       EOC_PULSE_OUT,
   input  wire logic       WINDOW_COMPARE_OUT,
   input  wire logic [7:0] RESULT_HIGH_BYTE_OUT,
   input  wire logic [7:0] RESULT_LOW_BYTE_OUT,
   input  wire logic       TRACKING_OUT,
   input  wire logic       CONVERTING_OUT,
   input  wire logic       POWER_ON_OUT,
   input  wire logic       SAR_CLK_OUT
);
   logic [4:0] sar_count;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // Conversion clocks seen in the current conversion
   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN)
         sar_count <= 5'h00;
      else if (CONVERTING_OUT)
         sar_count <= sar_count + {4'h0, SAR_CLK_OUT};
      else
         sar_count <= 5'h00;
   end
   one_state_a: assert property (!(TRACKING_OUT && CONVERTING_OUT))
      else $error("tracking and converting at once");
   conv_busy_a: assert property (CONVERTING_OUT |-> CONV_BUSY_BIT_OUT)
      else $error("converting without busy");
   sar_in_conv_a: assert property (SAR_CLK_OUT |-> CONVERTING_OUT)
      else $error("conversion clock outside a conversion");
   sar_count_a: assert property ($fell(CONVERTING_OUT) |-> sar_count == 5'h0d)
      else $error("conversion clock count wrong");
   eoc_set_a: assert property (EOC_PULSE_OUT |-> EOC_FLAG_OUT && WINDOW_COMPARE_OUT && !CONV_BUSY_BIT_OUT)
      else $error("end event without flag or compare");
   busy_fall_a: assert property ($fell(CONV_BUSY_BIT_OUT) && (BURST_ENABLE_BIT_IN || REPEAT_COUNT_FIELD_IN == 2'h0) |-> EOC_PULSE_OUT)
      else $error("busy fell without end event");
   result_hold_a: assert property (!EOC_PULSE_OUT |-> $stable({RESULT_HIGH_BYTE_OUT, RESULT_LOW_BYTE_OUT}))
      else $error("result changed without end event");
   pre_start_a: assert property ($rose(CONV_BUSY_BIT_OUT) && !BURST_ENABLE_BIT_IN && TRACK_MODE_FIELD_IN == `SAB_MODE_PRE |-> CONVERTING_OUT)
      else $error("pre mode did not convert at once");
   // A powered-down burst start spends its power-up time before tracking
   post_start_a: assert property ($rose(CONV_BUSY_BIT_OUT) && TRACK_MODE_FIELD_IN != `SAB_MODE_PRE &&
      (CONVERTER_ENABLE_BIT_IN || !BURST_ENABLE_BIT_IN) |-> TRACKING_OUT)
      else $error("no tracking after start");
   after_conv_a: assert property ($fell(CONVERTING_OUT) && !BURST_ENABLE_BIT_IN |-> TRACKING_OUT == (TRACK_MODE_FIELD_IN != `SAB_MODE_POST))
      else $error("tracking wrong after conversion");
   conv_power_a: assert property (CONVERTING_OUT |-> POWER_ON_OUT)
      else $error("converting while powered down");
   burst_done_c: cover property (EOC_PULSE_OUT && BURST_ENABLE_BIT_IN);
   rpt16_done_c: cover property (EOC_PULSE_OUT && REPEAT_COUNT_FIELD_IN == `SAB_RPT_16);
   post_stop_c: cover property ($fell(CONVERTING_OUT) && TRACK_MODE_FIELD_IN == `SAB_MODE_POST);
endmodule

bind sab_sequencer sab_sequencer_monitor u_sab_sequencer_monitor (
   .MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .BURST_ENABLE_BIT_IN(BURST_ENABLE_BIT_IN),
   .CONVERTER_ENABLE_BIT_IN(CONVERTER_ENABLE_BIT_IN),
   .TRACK_MODE_FIELD_IN(TRACK_MODE_FIELD_IN), .REPEAT_COUNT_FIELD_IN(REPEAT_COUNT_FIELD_IN),
   .CONV_BUSY_BIT_OUT(CONV_BUSY_BIT_OUT), .EOC_FLAG_OUT(EOC_FLAG_OUT), .EOC_PULSE_OUT(EOC_PULSE_OUT),
   .WINDOW_COMPARE_OUT(WINDOW_COMPARE_OUT), .RESULT_HIGH_BYTE_OUT(RESULT_HIGH_BYTE_OUT),
   .RESULT_LOW_BYTE_OUT(RESULT_LOW_BYTE_OUT), .TRACKING_OUT(TRACKING_OUT), .CONVERTING_OUT(CONVERTING_OUT),
   .POWER_ON_OUT(POWER_ON_OUT), .SAR_CLK_OUT(SAR_CLK_OUT));

/* verif/tb_top.sv */
// Self-checking bench for the converter sequencer with the analog core model.
// Assumes a 100 MHz system clock and the hand-over timing of the sequencer.
`timescale 1ns/1ps
`include "sab_defines.svh"

module tb_top;
   logic        mclk = 1'b0, rst_b = 1'b0, start = 1'b0, burst = 1'b0, en = 1'b1, ljst = 1'b0, clr = 1'b0;
   logic [4:0]  div = 5'h00, pwr = 5'h00;
   logic [1:0]  tk = 2'h0, tm = 2'h2, rpt = 2'h0;
   logic [11:0] code = 12'h000, sar;
   logic [7:0]  hi, lo;
   logic [31:0] r;
   logic        busy, eoc, eocp, win, trk, conv, pwr_on, sclk, osc;
   integer      seed = 32'h3c3221ee;
   int          mismatches = 0, comparisons = 0, cyc, ns, sum, cnt;

   sab_sequencer u_sab_sequencer (.MCLK_IN(mclk), .RST_B_IN(rst_b), .BURST_OSC_IN(osc), .CONV_START_IN(start),
      .BURST_ENABLE_BIT_IN(burst), .CONVERTER_ENABLE_BIT_IN(en), .SAR_CLK_DIVIDER_IN(div),
      .TRACK_TIME_FIELD_IN(tk), .TRACK_MODE_FIELD_IN(tm), .POWERUP_TIME_FIELD_IN(pwr), .JUSTIFY_BIT_IN(ljst),
      .REPEAT_COUNT_FIELD_IN(rpt), .EOC_FLAG_CLR_IN(clr), .SAR_DATA_IN(sar), .CONV_BUSY_BIT_OUT(busy),
      .EOC_FLAG_OUT(eoc), .EOC_PULSE_OUT(eocp), .WINDOW_COMPARE_OUT(win), .RESULT_HIGH_BYTE_OUT(hi),
      .RESULT_LOW_BYTE_OUT(lo), .TRACKING_OUT(trk), .CONVERTING_OUT(conv), .POWER_ON_OUT(pwr_on),
      .SAR_CLK_OUT(sclk));
   sab_analog_model u_sab_analog_model (.conv_in(conv), .code_in(code), .osc_out(osc), .data_out(sar));

   initial begin
      forever #5 mclk = ~mclk;
   end

   function automatic logic [15:0] fmt(logic [11:0] c, logic l);
      return l ? {c, 4'h0} : {4'h0, c};
   endfunction

   function automatic int span(logic [1:0] m, logic [4:0] d, logic [1:0] t);
      return 13 * (d + 1) + 2 + ((m == `SAB_MODE_PRE) ? 0 : t + 2);
   endfunction

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Start pin held four clocks, so starts are never closer than that
   task automatic kick();
      @(posedge mclk) start <= 1'b1;
      repeat (4) @(posedge mclk);
      start <= 1'b0;
   endtask

   // One start; measures busy length and conversion clocks; dup adds a start while busy
   task automatic run(input logic dup, output int c, output int n);
      fork
         kick();
         if (dup) begin
            repeat (8) @(posedge mclk);
            kick();
         end
      join_none
      c = 0;
      n = 0;
      while (busy !== 1'b1 && c < 50) begin
         @(posedge mclk);
         #1;
         c++;
      end
      c = 0;
      while (busy !== 1'b0 && c < 20000) begin
         @(posedge mclk);
         #1;
         c++;
         n += sclk;
      end
   endtask

   initial begin
      #300_000;
      mismatches++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      chk("reset result", 16'h0000, {hi, lo});
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         tm <= (i < 2) ? `SAB_MODE_PRE : (i < 4) ? `SAB_MODE_POST : `SAB_MODE_DUAL;
         ljst <= i[0];
         div <= (i == 0) ? 5'h03 : {3'h0, r[1:0]};
         tk <= r[15:14];
         code <= (i == 1) ? 12'hfff : r[13:2];
         run(i == 0, cyc, ns);
         chk("busy span", span(tm, div, tk), cyc);
         chk("conversion clocks", 13, ns);
         chk("result", fmt(code, ljst), {hi, lo});
         chk("eoc pulse", 1, eocp);
         chk("window strobe", 1, win);
         clr <= 1'b1;
         @(posedge mclk);
         clr <= 1'b0;
         @(posedge mclk);
         #1;
         chk("eoc cleared", 0, eoc);
         if (i == 0) begin
            cnt = 0;
            repeat (20) begin
               @(posedge mclk);
               #1;
               cnt += busy;
            end
            chk("start while busy", 0, cnt);
         end
      end
      rpt <= `SAB_RPT_4;
      ljst <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         sum = 0;
         for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            code <= r[11:0];
            sum += r[11:0];
            run(1'b0, cyc, ns);
            chk("series eoc pulse", k == 3, eocp);
         end
         chk("series sum", sum, {hi, lo});
      end
      for (int j = 0; j < 4; j++) begin
         r = $random(seed);
         burst <= 1'b1;
         rpt <= j[1:0];
         en <= j[0];
         tm <= j[1] ? `SAB_MODE_DUAL : `SAB_MODE_POST;
         pwr <= {3'h0, r[1:0]};
         div <= {3'h0, r[3:2]};
         code <= r[15:4];
         cnt = (j == 0) ? 1 : 2 << j;
         run(1'b0, cyc, ns);
         chk("burst conversion clocks", 13 * cnt, ns);
         chk("burst sum", r[15:4] * cnt, {hi, lo});
         chk("burst eoc pulse", 1, eocp);
         repeat (8) @(posedge mclk);
         #1;
         chk("idle power", j[0], pwr_on);
      end
      test_done();
   end
endmodule
